// ===== hdl/seerw_device.sv
// EEPROM device end: bit engine, address counter, array and write cycle
//
// Overview of operation
// - Two acknowledged address bytes follow write address
// - Byte write takes one acknowledged data byte
// - STOP after write starts programming cycle
// - Bus ignored while programming runs
// - Page write accepts up to 64 bytes
// - Write increments only low six address bits
// - Over 64 bytes wraps within page
// - No address acknowledge while programming
// - Read address has direction bit one
// - Counter holds last address plus one
// - Read: acknowledge, send byte, increment counter
// - Host nack then STOP ends read
// - Host acknowledge requests next read byte
// - Read counter wraps past top address
// - Host ends sequential read with nack, STOP
// - Random read uses dummy write first
// - New START cancels pending write, keeps address
// - Device type bits must be 1010
// - Select bits must match chip select pins
// - Write protect high blocks programming; the timed cycle still runs here, only the array write is skipped
// - Device address acknowledged on ninth clock only when it matches; every later received byte acknowledged on ninth clock
//
// The register addresses and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`include "seerw_map.svh"
module seerw_device
  import seerw_pkg::*;
#(
  parameter int PROG_CYCLES = `SEERW_PROG_CYC,
  parameter int ADDR_W = `SEERW_ADDR_W,
  parameter int PAGE_W = `SEERW_PAGE_W
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Link
  seerw_link_if.device link,
  // Straps and status
  input wire logic [2:0] chipSelectPins,
  input wire logic writeProtect,
  output logic programming
);
  typedef enum logic [2:0] {
    SEERW_IDLE, SEERW_DEVADDR, SEERW_ADDRHI, SEERW_ADDRLO, SEERW_WDATA, SEERW_RDATA, SEERW_RACK
  } seerw_dstate_e;

  // ==========================================================
  // Synchronisers and edge detection
  logic [1:0] sclSync;
  logic [1:0] sdaSync;
  logic sclPrev;
  logic sdaPrev;
  // Strap pins: write protect above the three select bits
  logic [3:0] strapSync0;
  logic [3:0] strapSync1;
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      sclSync <= 2'h3;
      sdaSync <= 2'h3;
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
      strapSync0 <= 4'h0;
      strapSync1 <= 4'h0;
    end else begin
      sclSync <= {sclSync[0], link.scl};
      sdaSync <= {sdaSync[0], link.sda};
      sclPrev <= sclSync[1];
      sdaPrev <= sdaSync[1];
      strapSync0 <= {writeProtect, chipSelectPins};
      strapSync1 <= strapSync0;
    end
  end
  wire [2:0] csPins = strapSync1[2:0];
  wire wpPin = strapSync1[3];
  wire sclRise = sclSync[1] & ~sclPrev;
  wire sclFall = ~sclSync[1] & sclPrev;
  wire startSeen = sclSync[1] & sclPrev & sdaPrev & ~sdaSync[1];
  wire stopSeen = sclSync[1] & sclPrev & ~sdaPrev & sdaSync[1];

  // ==========================================================
  // Storage
  logic [7:0] memArray [0:(1 << ADDR_W) - 1];
  logic [7:0] pageBuf [0:(1 << PAGE_W) - 1];
  logic [(1 << PAGE_W) - 1:0] pageDirty;

  seerw_dstate_e state;
  logic [3:0] bitCnt;
  logic [7:0] shiftReg;
  logic [ADDR_W - 1:0] addrCnt;
  logic [ADDR_W - 1:0] pageBase;
  logic writePending;
  logic [31:0] progCnt;
  logic [PAGE_W:0] flushIdx;
  logic isRead;
  logic sdaOut;

  function automatic logic [ADDR_W - 1:0] pageIncr(input logic [ADDR_W - 1:0] a);
    pageIncr = {a[ADDR_W - 1:PAGE_W], a[PAGE_W - 1:0] + 1'b1};
  endfunction

  // ==========================================================
  // Programming cycle timer
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      programming <= 1'b0;
      progCnt <= 32'h0;
    end else if (programming) begin
      if (progCnt == 32'(PROG_CYCLES - 1)) begin
        programming <= 1'b0;
      end
      progCnt <= progCnt + 32'h1;
    end else if (stopSeen && writePending) begin
      programming <= 1'b1;
      progCnt <= 32'h0;
    end
  end

  // Copy latched page into the array during the cycle
  always_ff @(posedge clock) begin
    if (programming && !flushIdx[PAGE_W] && pageDirty[flushIdx[PAGE_W - 1:0]] && !wpPin) begin
      memArray[{pageBase[ADDR_W - 1:PAGE_W], flushIdx[PAGE_W - 1:0]}] <= pageBuf[flushIdx[PAGE_W - 1:0]];
    end
    if (state == SEERW_WDATA && sclRise && bitCnt == 4'd7) begin
      pageBuf[addrCnt[PAGE_W - 1:0]] <= {shiftReg[6:0], sdaSync[1]};
    end
  end

  // ==========================================================
  // Protocol engine
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state <= SEERW_IDLE;
      bitCnt <= 4'h0;
      shiftReg <= 8'h0;
      addrCnt <= '0;
      pageBase <= '0;
      pageDirty <= '0;
      writePending <= 1'b0;
      flushIdx <= '0;
      isRead <= 1'b0;
      sdaOut <= 1'b1;
    end else if (programming) begin
      state <= SEERW_IDLE;
      sdaOut <= 1'b1;
      writePending <= 1'b0;
      if (!flushIdx[PAGE_W]) begin
        flushIdx <= flushIdx + 1'b1;
      end
    end else if (startSeen) begin
      state <= SEERW_DEVADDR;
      bitCnt <= 4'h0;
      sdaOut <= 1'b1;
      writePending <= 1'b0;
      pageDirty <= '0;
    end else if (stopSeen) begin
      state <= SEERW_IDLE;
      sdaOut <= 1'b1;
      flushIdx <= '0;
    end else if (state != SEERW_IDLE) begin
      if (sclRise) begin
        if (bitCnt < 4'd8) begin
          shiftReg <= {shiftReg[6:0], sdaSync[1]};
        end
        bitCnt <= bitCnt + 4'h1;
        // Host acknowledge keeps us here until scl falls
        if (state == SEERW_RACK && bitCnt == 4'd0 && sdaSync[1]) begin
          state <= SEERW_IDLE;
        end
      end
      if (sclFall) begin
        case (state)
          SEERW_DEVADDR: begin
            if (bitCnt == 4'd8) begin
              if (shiftReg[7:4] == `SEERW_DEV_TYPE && shiftReg[3:1] == csPins) begin
                sdaOut <= 1'b0;
                isRead <= shiftReg[0];
              end else begin
                state <= SEERW_IDLE;
              end
            end else if (bitCnt == 4'd9) begin
              bitCnt <= 4'h0;
              if (isRead) begin
                state <= SEERW_RDATA;
                sdaOut <= memArray[addrCnt][7];
                addrCnt <= addrCnt + 1'b1;
              end else begin
                state <= SEERW_ADDRHI;
                sdaOut <= 1'b1;
              end
            end
          end
          SEERW_ADDRHI, SEERW_ADDRLO, SEERW_WDATA: begin
            if (bitCnt == 4'd8) begin
              sdaOut <= 1'b0;
              if (state == SEERW_ADDRHI) begin
                addrCnt[ADDR_W - 1:8] <= shiftReg[ADDR_W - 9:0];
              end else if (state == SEERW_ADDRLO) begin
                addrCnt[7:0] <= shiftReg;
                pageBase[7:0] <= shiftReg;
                pageBase[ADDR_W - 1:8] <= addrCnt[ADDR_W - 1:8];
              end else begin
                pageDirty[addrCnt[PAGE_W - 1:0]] <= 1'b1;
                writePending <= 1'b1;
                addrCnt <= pageIncr(addrCnt);
              end
            end else if (bitCnt == 4'd9) begin
              bitCnt <= 4'h0;
              sdaOut <= 1'b1;
              state <= (state == SEERW_ADDRHI) ? SEERW_ADDRLO : SEERW_WDATA;
            end
          end
          SEERW_RDATA: begin
            if (bitCnt == 4'd8) begin
              sdaOut <= 1'b1;
              state <= SEERW_RACK;
              bitCnt <= 4'h0;
            end else begin
              sdaOut <= memArray[addrCnt - 1'b1][3'(7 - bitCnt)];
            end
          end
          SEERW_RACK: begin
            if (bitCnt == 4'd1) begin
              bitCnt <= 4'h0;
              state <= SEERW_RDATA;
              sdaOut <= memArray[addrCnt][7];
              addrCnt <= addrCnt + 1'b1;
            end
          end
          default: state <= SEERW_IDLE;
        endcase
      end
    end
  end

  // Open-drain output: drive only a low
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      link.devSdaOut <= 1'b1;
      link.devSdaOe <= 1'b0;
    end else begin
      link.devSdaOut <= 1'b0;
      link.devSdaOe <= ~sdaOut;
    end
  end
endmodule

// ===== hdl/seerw_host.sv
// Host controller end: AHB-Lite command registers driving the two-wire link
`timescale 1ns/1ps
`include "seerw_map.svh"
module seerw_host
  import seerw_pkg::*;
#(
  parameter int HALF_BIT = `SEERW_HALF_BIT
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Link
  seerw_link_if.host link
);
  typedef enum logic [2:0] {
    SEERW_H_IDLE, SEERW_H_START, SEERW_H_BIT, SEERW_H_STOP
  } seerw_hstate_e;

  // ==========================================================
  // Bus slave
  logic wrPend;
  logic [31:0] wrAddr;
  logic rdPend;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic ackSeen;
  logic nackOut;
  seerw_cmd_e cmd;
  seerw_hstate_e hstate;
  wire busy = (hstate != SEERW_H_IDLE) || (cmd != SEERW_CMD_NONE);
  wire take = hsel && hready && htrans[1];

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      wrPend <= 1'b0;
      rdPend <= 1'b0;
      wrAddr <= 32'h0;
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wrPend <= take && hwrite;
      rdPend <= take && !hwrite;
      if (take) begin
        wrAddr <= haddr;
      end
      if (take && !hwrite) begin
        case (haddr)
          `SEERW_REG_WDATA: hrdata <= {24'h0, wdata};
          `SEERW_REG_RDATA: hrdata <= {24'h0, rdata};
          `SEERW_REG_STATUS: hrdata <= {30'h0, ackSeen, busy};
          default: hrdata <= 32'h0;
        endcase
      end
    end
  end

  // ==========================================================
  // Command register and bit engine
  logic [7:0] shiftReg;
  logic [3:0] bitCnt;
  logic [7:0] divCnt;
  logic [1:0] phase;
  logic [1:0] sdaSync;
  logic isRx;
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      sdaSync <= 2'h3;
    end else begin
      sdaSync <= {sdaSync[0], link.sda};
    end
  end
  wire tick = (divCnt == 8'(HALF_BIT - 1));

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cmd <= SEERW_CMD_NONE;
      wdata <= 8'h0;
      nackOut <= 1'b0;
      isRx <= 1'b0;
    end else if (wrPend && wrAddr == `SEERW_REG_WDATA) begin
      wdata <= hwdata[7:0];
    end else if (wrPend && wrAddr == `SEERW_REG_CTRL && !busy) begin
      nackOut <= hwdata[`SEERW_CTRL_NACK];
      isRx <= hwdata[`SEERW_CTRL_READ];
      if (hwdata[`SEERW_CTRL_START]) begin
        cmd <= SEERW_CMD_START;
      end else if (hwdata[`SEERW_CTRL_STOP]) begin
        cmd <= SEERW_CMD_STOP;
      end else if (hwdata[`SEERW_CTRL_WRITE] || hwdata[`SEERW_CTRL_READ]) begin
        cmd <= SEERW_CMD_BYTE;
      end
    end else if (hstate != SEERW_H_IDLE) begin
      cmd <= SEERW_CMD_NONE;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      hstate <= SEERW_H_IDLE;
      divCnt <= 8'h0;
      phase <= 2'h0;
      bitCnt <= 4'h0;
      shiftReg <= 8'h0;
      rdata <= 8'h0;
      ackSeen <= 1'b0;
      link.scl <= 1'b1;
      link.hostSdaOut <= 1'b1;
      link.hostSdaOe <= 1'b0;
    end else begin
      divCnt <= tick ? 8'h0 : divCnt + 8'h1;
      case (hstate)
        SEERW_H_IDLE: begin
          phase <= 2'h0;
          if (cmd == SEERW_CMD_START) begin
            hstate <= SEERW_H_START;
          end else if (cmd == SEERW_CMD_STOP) begin
            hstate <= SEERW_H_STOP;
          end else if (cmd == SEERW_CMD_BYTE) begin
            hstate <= SEERW_H_BIT;
            bitCnt <= 4'h0;
            shiftReg <= isRx ? 8'hff : wdata;
          end
        end
        SEERW_H_START, SEERW_H_STOP: if (tick) begin
          phase <= phase + 2'h1;
          case (phase)
            2'h0: begin
              link.hostSdaOe <= (hstate == SEERW_H_STOP);
              link.hostSdaOut <= 1'b0;
            end
            2'h1: link.scl <= 1'b1;
            2'h2: link.hostSdaOe <= (hstate == SEERW_H_START);
            default: begin
              if (hstate == SEERW_H_START) begin
                link.scl <= 1'b0;
              end
              hstate <= SEERW_H_IDLE;
            end
          endcase
        end
        SEERW_H_BIT: if (tick) begin
          phase <= phase + 2'h1;
          case (phase)
            2'h0: begin
              link.hostSdaOut <= 1'b0;
              link.hostSdaOe <= (bitCnt < 4'd8) ? ~shiftReg[7] : (isRx && !nackOut);
            end
            2'h1: link.scl <= 1'b1;
            2'h2: begin
              if (bitCnt < 4'd8) begin
                shiftReg <= {shiftReg[6:0], sdaSync[1]};
              end else begin
                ackSeen <= ~sdaSync[1];
              end
            end
            default: begin
              link.scl <= 1'b0;
              bitCnt <= bitCnt + 4'h1;
              if (bitCnt == 4'd8) begin
                link.hostSdaOe <= 1'b0;
                rdata <= shiftReg;
                hstate <= SEERW_H_IDLE;
              end
            end
          endcase
        end
        default: hstate <= SEERW_H_IDLE;
      endcase
    end
  end
endmodule

// ===== hdl/seerw_link_if.sv
// Two-wire link between host controller and EEPROM device
`timescale 1ns/1ps
interface seerw_link_if;
  logic scl;
  logic hostSdaOut;
  logic hostSdaOe;
  logic devSdaOut;
  logic devSdaOe;
  wire sda = ~((hostSdaOe & ~hostSdaOut) | (devSdaOe & ~devSdaOut));
  modport host (output scl, output hostSdaOut, output hostSdaOe, input sda);
  modport device (input scl, output devSdaOut, output devSdaOe, input sda);
endinterface

// ===== hdl/seerw_map.svh
// Offsets, field positions and timing counts for the serial EEPROM engine
`ifndef SEERW_MAP_SVH
`define SEERW_MAP_SVH
`define SEERW_CLK_HZ 10000000
`define SEERW_PROG_MS 5
`define SEERW_PROG_CYC ((`SEERW_CLK_HZ / 1000) * `SEERW_PROG_MS)
`define SEERW_DEV_TYPE 4'ha
`define SEERW_ARRAY_BYTES 16384
`define SEERW_ADDR_W 14
`define SEERW_PAGE_W 6
`define SEERW_HALF_BIT 4
`define SEERW_REG_CTRL 32'h00000000
`define SEERW_REG_ADDR 32'h00000004
`define SEERW_REG_WDATA 32'h00000008
`define SEERW_REG_RDATA 32'h0000000c
`define SEERW_REG_STATUS 32'h00000010
`define SEERW_REG_PINS 32'h00000014
`define SEERW_CTRL_START 0
`define SEERW_CTRL_STOP 1
`define SEERW_CTRL_WRITE 2
`define SEERW_CTRL_READ 3
`define SEERW_CTRL_NACK 4
`define SEERW_ST_BUSY 0
`define SEERW_ST_ACK 1
`endif

// ===== hdl/seerw_pkg.sv
// Types shared by both ends of the serial EEPROM link
package seerw_pkg;
  typedef enum logic [1:0] {
    SEERW_CMD_NONE,
    SEERW_CMD_START,
    SEERW_CMD_STOP,
    SEERW_CMD_BYTE
  } seerw_cmd_e;
  typedef logic [7:0] seerw_byte_t;
endpackage

// ===== sim/seerw_bench.sv
// Bench joining host and device over the link, driven over AHB-Lite
`timescale 1ns/1ps
`include "seerw_map.svh"
module seerw_bench
  import seerw_pkg::*;
;
  localparam int PROG = 1000;
  localparam logic [4:0] CST = 5'h1 << `SEERW_CTRL_START;
  localparam logic [4:0] CSP = 5'h1 << `SEERW_CTRL_STOP;
  localparam logic [4:0] CWR = 5'h1 << `SEERW_CTRL_WRITE;
  localparam logic [4:0] CRD = 5'h1 << `SEERW_CTRL_READ;
  localparam logic [4:0] CNK = 5'h1 << `SEERW_CTRL_NACK;
  // Word address as sent, byte written and read back
  localparam logic [23:0] ROWS [4] = '{24'h00003c, 24'h3fffc3, 24'hc0555a, 24'h123481};
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [2:0] chipSelectPins = 3'h5;
  logic writeProtect = 1'b0;
  logic programming;
  logic [31:0] rd;
  logic ack;
  seerw_byte_t got [64];
  int bad_count = 0;
  int checks_done = 0;
  seerw_link_if link();
  seerw_host u_seerw_host (.clock(clock), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .link(link.host));
  seerw_device #(.PROG_CYCLES(PROG)) u_seerw_device (.clock(clock), .sys_rst(sys_rst), .link(link.device),
    .chipSelectPins(chipSelectPins), .writeProtect(writeProtect), .programming(programming));
  seerw_link_chk #(.PROG_CYCLES(PROG)) u_seerw_link_chk (.clock(clock), .sys_rst(sys_rst), .scl(link.scl),
    .hostSdaOut(link.hostSdaOut), .hostSdaOe(link.hostSdaOe), .devSdaOut(link.devSdaOut),
    .devSdaOe(link.devSdaOe), .sda(link.sda), .programming(programming));
  always #50 clock = ~clock;
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic give_up();
    check(32'h0, 32'h1);
    summarize();
  endtask
  task automatic ready();
    int n;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) give_up();
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    ready();
    rd = hrdata;
  endtask
  task automatic cmd(input logic [4:0] bits);
    int n;
    ahb(1'b1, `SEERW_REG_CTRL, {27'h0, bits});
    n = 0;
    do begin
      ahb(1'b0, `SEERW_REG_STATUS, 32'h0);
      n++;
    end while (rd[`SEERW_ST_BUSY] !== 1'b0 && n < 500);
    if (rd[`SEERW_ST_BUSY] !== 1'b0) give_up();
    ack = rd[`SEERW_ST_ACK];
  endtask
  task automatic sendb(input seerw_byte_t b);
    ahb(1'b1, `SEERW_REG_WDATA, {24'h0, b});
    cmd(CWR);
  endtask
  task automatic dev(input logic rw);
    cmd(CST);
    sendb({4'ha, chipSelectPins, rw});
  endtask
  task automatic poll(input logic rw);
    int n;
    n = 0;
    do begin
      dev(rw);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1) give_up();
  endtask
  task automatic wr(input logic [15:0] a, input int n, input seerw_byte_t b);
    int k;
    poll(1'b0);
    sendb(a[15:8]);
    check(ack, 1'b1);
    sendb(a[7:0]);
    check(ack, 1'b1);
    for (k = 0; k < n; k++) begin
      sendb(b ^ 8'(k));
      if (writeProtect !== 1'b1) check(ack, 1'b1);
    end
    cmd(CSP);
    check(programming, 1'b1);
  endtask
  task automatic rd_seq(input logic [15:0] a, input int n, input logic dummy);
    int k;
    if (dummy) begin
      poll(1'b0);
      sendb(a[15:8]);
      sendb(a[7:0]);
      check(ack, 1'b1);
      dev(1'b1);
      check(ack, 1'b1);
    end else begin
      poll(1'b1);
    end
    for (k = 0; k < n; k++) begin
      cmd(CRD | (k == n - 1 ? CNK : 5'h0));
      ahb(1'b0, `SEERW_REG_RDATA, 32'h0);
      got[k] = rd[7:0];
    end
    cmd(CSP);
  endtask
  initial begin
    int i;
    int k;
    repeat (5) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    check({link.scl, link.sda, programming}, 3'b110);
    check(hrdata, 32'h0);
    ahb(1'b0, `SEERW_REG_ADDR, 32'h0);
    check(rd, 32'h0);
    ahb(1'b1, `SEERW_REG_WDATA, 32'h0000005c);
    ahb(1'b0, `SEERW_REG_WDATA, 32'h0);
    check(rd, 32'h0000005c);
    for (i = 0; i < 4; i++) begin
      wr(ROWS[i][23:8], 1, ROWS[i][7:0]);
      dev(1'b0);
      check(ack, 1'b0);
      rd_seq({2'b00, ROWS[i][21:8]}, 1, 1'b1);
      check(got[0], ROWS[i][7:0]);
    end
    rd_seq(16'h3fff, 2, 1'b1);
    check({got[0], got[1]}, 16'hc33c);
    wr(16'h013e, 66, 8'ha5);
    rd_seq(16'h0100, 64, 1'b1);
    for (k = 0; k < 64; k++) begin
      check(got[k], 8'ha5 ^ 8'(k + 2));
    end
    rd_seq(16'h0110, 1, 1'b1);
    rd_seq(16'h0000, 1, 1'b0);
    check(got[0], 8'ha5 ^ 8'h13);
    poll(1'b0);
    sendb(8'h01);
    sendb(8'h20);
    sendb(8'hee);
    rd_seq(16'h0120, 1, 1'b1);
    check({programming, got[0]}, {1'b0, 8'ha5 ^ 8'h22});
    cmd(CST);
    sendb({4'hb, chipSelectPins, 1'b0});
    check(ack, 1'b0);
    cmd(CST);
    sendb({4'ha, ~chipSelectPins, 1'b1});
    check(ack, 1'b0);
    cmd(CSP);
    chipSelectPins <= 3'h2;
    writeProtect <= 1'b1;
    wr(16'h0055, 1, 8'h11);
    rd_seq(16'h0055, 1, 1'b1);
    writeProtect <= 1'b0;
    check({hresp, got[0]}, {1'b0, 8'h5a});
    summarize();
  end
endmodule

// ===== sim/seerw_link_chk.sv
// Assertions on the two-wire link between host and device
`timescale 1ns/1ps
module seerw_link_chk #(
  parameter int PROG_CYCLES = 200
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Link wires and device status
  input wire logic scl,
  input wire logic hostSdaOut,
  input wire logic hostSdaOe,
  input wire logic devSdaOut,
  input wire logic devSdaOe,
  input wire logic sda,
  input wire logic programming
);
  logic sclQ;
  logic sdaQ;
  logic stopNow;
  int progCount;
  int stopAge;
  assign stopNow = scl && sclQ && sda && !sdaQ;
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      sclQ <= 1'b1;
      sdaQ <= 1'b1;
    end else begin
      sclQ <= scl;
      sdaQ <= sda;
    end
  end
  // Cycles spent programming and since the last STOP
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      progCount <= 0;
      stopAge <= 1000;
    end else begin
      progCount <= programming ? progCount + 1 : 0;
      stopAge <= stopNow ? 0 : (stopAge < 1000 ? stopAge + 1 : stopAge);
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence sclHeld;
    scl && sclQ;
  endsequence
  sequence progBegins;
    $rose(programming);
  endsequence
  chk_prog_silent: assert property (programming |-> !devSdaOe)
    else $error("device drives sda while programming");
  chk_prog_after_stop: assert property (progBegins |-> stopAge <= 16)
    else $error("write cycle began without a STOP");
  chk_prog_idle_bus: assert property (progBegins |-> scl && sda)
    else $error("write cycle began on a busy bus");
  chk_prog_len_bound: assert property (progCount <= PROG_CYCLES + 1)
    else $error("write cycle too long");
  chk_ack_stands: assert property (sclHeld |-> $stable(devSdaOe))
    else $error("device sda changed while scl high");
  chk_ack_pulls_low: assert property (devSdaOe |-> !devSdaOut)
    else $error("device drives sda high");
  chk_dev_edge_low: assert property ($rose(devSdaOe) |-> !scl && !sclQ)
    else $error("device took sda while scl high");
  chk_no_clash: assert property (scl |-> !(devSdaOe && hostSdaOe))
    else $error("host and device drive sda together");
  chk_host_pulls_low: assert property (hostSdaOe |-> !hostSdaOut)
    else $error("host drives sda high");
endmodule
